// ===== rtl/synth_cal_pkg.sv
// Register map, field layout, reset values and wait timing for the synthesizer
// calibration and loop-control register slice.
// Assumes a 250 MHz system clock that also serves as the always-on time base.
package synth_cal_pkg;

   // Printed register indices; byte address is four times the index
   localparam logic [7:0]  IDX_SYNTH1_CALIBRATION_WAIT = 8'h77;
   localparam logic [7:0]  IDX_SYNTH1_LOOP_BANDWIDTH   = 8'h78;
   localparam logic [7:0]  IDX_SYNTH2_PUMP_STRETCH     = 8'h83;
   localparam logic [7:0]  IDX_SYNTH2_FILTER_ORDER     = 8'h84;
   // Status register of the calibration sequencer
   localparam logic [7:0]  IDX_CALIBRATION_STATUS      = 8'h85;

   localparam int          ADDR_W = 10;

   // Field positions
   localparam int          CLSD_WAIT_LSB   = 2;
   localparam int          OSC_WAIT_LSB    = 0;
   localparam int          NARROW_BW_BIT   = 0;
   localparam int          STRETCH_BIT     = 7;
   localparam int          FILTER_LSB      = 0;

   // Field reset values
   localparam logic [1:0]  CLSD_WAIT_RST   = 2'h0;
   localparam logic [1:0]  OSC_WAIT_RST    = 2'h1;
   localparam logic        NARROW_BW_RST   = 1'h0;
   localparam logic        STRETCH_RST     = 1'h0;
   localparam logic [2:0]  FILTER_RST      = 3'h3;

   // Filter order codes
   localparam logic [2:0]  FILTER_SECOND_ORDER = 3'h3;
   localparam logic [2:0]  FILTER_THIRD_ORDER  = 3'h7;

   // Wait times, microseconds, and the clock rate
   localparam longint      CLK_MHZ          = 250;
   localparam longint      CLSD_WAIT_US0    = 30;
   localparam longint      CLSD_WAIT_US1    = 300;
   localparam longint      CLSD_WAIT_US2    = 30000;
   localparam longint      CLSD_WAIT_US3    = 300000;
   localparam longint      OSC_WAIT_US0     = 20;
   localparam longint      OSC_WAIT_US1     = 400;
   localparam longint      OSC_WAIT_US2     = 8000;
   localparam longint      OSC_WAIT_US3     = 200000;

   localparam int          CNT_W = 27;
   localparam logic [CNT_W-1:0] CLSD_CYC0 = CNT_W'(CLSD_WAIT_US0 * CLK_MHZ);
   localparam logic [CNT_W-1:0] CLSD_CYC1 = CNT_W'(CLSD_WAIT_US1 * CLK_MHZ);
   localparam logic [CNT_W-1:0] CLSD_CYC2 = CNT_W'(CLSD_WAIT_US2 * CLK_MHZ);
   localparam logic [CNT_W-1:0] CLSD_CYC3 = CNT_W'(CLSD_WAIT_US3 * CLK_MHZ);
   localparam logic [CNT_W-1:0] OSC_CYC0  = CNT_W'(OSC_WAIT_US0 * CLK_MHZ);
   localparam logic [CNT_W-1:0] OSC_CYC1  = CNT_W'(OSC_WAIT_US1 * CLK_MHZ);
   localparam logic [CNT_W-1:0] OSC_CYC2  = CNT_W'(OSC_WAIT_US2 * CLK_MHZ);
   localparam logic [CNT_W-1:0] OSC_CYC3  = CNT_W'(OSC_WAIT_US3 * CLK_MHZ);

   typedef enum logic [1:0] {
      CAL_IDLE,
      CAL_OSC_WAIT,
      CAL_CLSD_WAIT,
      CAL_DONE
   } cal_state_e;

endpackage

// ===== rtl/wait_timer.sv
// Down-counting wait timer for one calibration phase.
// Assumes load and the cycle count are stable in the load cycle.
`timescale 1ns/10ps
module wait_timer (
   // Clock and reset
   input  wire logic                           clk_in,
   input  wire logic                           resetn_in,
   // Control
   input  wire logic                           load_in,
   input  wire logic [synth_cal_pkg::CNT_W-1:0] cycles_in,
   // Status
   output logic                                expired_out
);
   import synth_cal_pkg::*;

   logic [CNT_W-1:0] count_q;
   logic             running_q;

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         count_q     <= '0;
         running_q   <= 1'b0;
         expired_out <= 1'b0;
      end else if (load_in) begin
         count_q     <= cycles_in - CNT_W'(1);
         running_q   <= 1'b1;
         expired_out <= 1'b0;
      end else if (running_q) begin
         count_q     <= count_q - CNT_W'(1);
         running_q   <= (count_q != '0);
         expired_out <= (count_q == '0);
      end else begin
         expired_out <= 1'b0;
      end
   end

endmodule

// ===== rtl/synth_cal_regs.sv
// Calibration and loop-control registers of the two synthesizers, with an
// Avalon-MM slave port and a calibration wait sequencer for the first one.
// Assumes a single 250 MHz clock; analog controls are plain register outputs.
//
// Notes on behaviour
// - The closed-loop wait code selects 30 us, 300 us, 30 ms or 300 ms of settling wait.
// - The oscillator wait code selects 20, 400, 8000 or 200000 us, and software uses code 1.
// - A set narrow-bandwidth bit drops the first synthesizer to its 200 Hz jitter-cleaner bandwidth.
// - The stretch bit widens the minimum pump pulse from 200 ps to about 600 ps.
// - Filter order code 3 gives a second-order and code 7 a third-order loop filter.
// - The second synthesizer's stretch and filter controls stand apart from the first's.
// - Reset leaves closed-loop wait 0, oscillator wait 1, both single bits 0 and filter order 3.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/10ps
module synth_cal_regs (
   // Clock and reset
   input  wire logic                              clk_in,
   input  wire logic                              resetn_in,
   // Avalon-MM slave
   input  wire logic [synth_cal_pkg::ADDR_W-1:0]  avs_address_in,
   input  wire logic                              avs_read_in,
   input  wire logic                              avs_write_in,
   input  wire logic [31:0]                       avs_writedata_in,
   input  wire logic [3:0]                        avs_byteenable_in,
   output logic [31:0]                            avs_readdata_out,
   output logic                                   avs_waitrequest_out,
   output logic [1:0]                             avs_response_out,
   // Calibration trigger
   input  wire logic                              cal_start_in,
   // Analog controls
   output logic                                   synth1_narrow_bandwidth_out,
   output logic                                   synth2_pump_pulse_stretch_out,
   output logic                                   synth2_second_order_out,
   output logic                                   synth2_third_order_out,
   // Calibration status
   output logic                                   cal_busy_out,
   output logic                                   cal_done_out
);
   import synth_cal_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Register storage

   logic [1:0] closed_loop_wait_q;
   logic [1:0] oscillator_wait_q;
   logic       narrow_bw_q;
   logic       stretch_q;
   logic [2:0] filter_order_q;
   logic       ack_q;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   wire [7:0] reg_idx    = avs_address_in[ADDR_W-1:2];
   wire       word_align = (avs_address_in[1:0] == 2'h0);
   wire       sel_wait   = word_align && (reg_idx == IDX_SYNTH1_CALIBRATION_WAIT);
   wire       sel_bw     = word_align && (reg_idx == IDX_SYNTH1_LOOP_BANDWIDTH);
   wire       sel_str    = word_align && (reg_idx == IDX_SYNTH2_PUMP_STRETCH);
   wire       sel_filt   = word_align && (reg_idx == IDX_SYNTH2_FILTER_ORDER);
   wire       sel_stat   = word_align && (reg_idx == IDX_CALIBRATION_STATUS);
   wire       mapped     = sel_wait | sel_bw | sel_str | sel_filt | sel_stat;
   wire       req        = avs_read_in | avs_write_in;
   // One wait cycle per access: answer on the edge after the request appears
   wire       take       = req && !ack_q;
   wire       wr_lane0   = take && avs_write_in && avs_byteenable_in[0];

   cal_state_e state_q;
   cal_state_e state_d;

   // Status is read only; a write to it is answered OKAY and dropped
   wire       stat_done  = (state_q == CAL_DONE);
   wire       stat_busy  = (state_q == CAL_OSC_WAIT) || (state_q == CAL_CLSD_WAIT);
   wire [1:0] resp_code  = mapped ? 2'h0 : 2'h3;

   // Reserved bits are never stored and read back as zero
   wire [31:0] rd_mux =
      sel_wait ? {28'h0, closed_loop_wait_q, oscillator_wait_q} :
      sel_bw   ? {31'h0, narrow_bw_q} :
      sel_str  ? {24'h0, stretch_q, 7'h0} :
      sel_filt ? {29'h0, filter_order_q} :
      sel_stat ? {30'h0, stat_done, stat_busy} :
                 32'h0;

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         ack_q               <= 1'b0;
         avs_readdata_out    <= 32'h0;
         avs_response_out    <= 2'h0;
      end else begin
         ack_q               <= take;
         avs_readdata_out    <= (take && avs_read_in) ? rd_mux : 32'h0;
         avs_response_out    <= take ? resp_code : 2'h0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         avs_waitrequest_out <= 1'b1;
      end else begin
         avs_waitrequest_out <= !take;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes

   // Write lands on the taking edge, so it is in place before the answer
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         closed_loop_wait_q <= CLSD_WAIT_RST;
         oscillator_wait_q  <= OSC_WAIT_RST;
         narrow_bw_q        <= NARROW_BW_RST;
         stretch_q          <= STRETCH_RST;
         filter_order_q     <= FILTER_RST;
      end else if (wr_lane0) begin
         if (sel_wait) begin
            closed_loop_wait_q <= avs_writedata_in[CLSD_WAIT_LSB +: 2];
            oscillator_wait_q  <= avs_writedata_in[OSC_WAIT_LSB +: 2];
         end
         if (sel_bw) begin
            narrow_bw_q <= avs_writedata_in[NARROW_BW_BIT];
         end
         // Separate storage keeps the second synthesizer independent
         if (sel_str) begin
            stretch_q <= avs_writedata_in[STRETCH_BIT];
         end
         if (sel_filt) begin
            filter_order_q <= avs_writedata_in[FILTER_LSB +: 3];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Analog control outputs

   // One cycle behind the registers, so each control changes on a clean edge
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         synth1_narrow_bandwidth_out   <= NARROW_BW_RST;
         synth2_pump_pulse_stretch_out <= STRETCH_RST;
         synth2_second_order_out       <= 1'b1;
         synth2_third_order_out        <= 1'b0;
      end else begin
         synth1_narrow_bandwidth_out   <= narrow_bw_q;
         synth2_pump_pulse_stretch_out <= stretch_q;
         // Reserved codes select neither filter; nothing stops software writing them
         synth2_second_order_out       <= (filter_order_q == FILTER_SECOND_ORDER);
         synth2_third_order_out        <= (filter_order_q == FILTER_THIRD_ORDER);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Calibration sequencer: oscillator wait, then closed-loop wait

   logic [CNT_W-1:0] osc_cycles;
   logic [CNT_W-1:0] clsd_cycles;
   logic             timer_load;
   logic             timer_expired;

   assign osc_cycles =
      (oscillator_wait_q == 2'h0) ? OSC_CYC0 :
      (oscillator_wait_q == 2'h1) ? OSC_CYC1 :
      (oscillator_wait_q == 2'h2) ? OSC_CYC2 : OSC_CYC3;

   assign clsd_cycles =
      (closed_loop_wait_q == 2'h0) ? CLSD_CYC0 :
      (closed_loop_wait_q == 2'h1) ? CLSD_CYC1 :
      (closed_loop_wait_q == 2'h2) ? CLSD_CYC2 : CLSD_CYC3;

   // A start during a wait is ignored, so a late pulse cannot stretch calibration
   always_comb begin
      state_d    = state_q;
      timer_load = 1'b0;
      case (state_q)
         CAL_IDLE, CAL_DONE: begin
            if (cal_start_in) begin
               state_d    = CAL_OSC_WAIT;
               timer_load = 1'b1;
            end
         end
         CAL_OSC_WAIT: begin
            if (timer_expired) begin
               state_d    = CAL_CLSD_WAIT;
               timer_load = 1'b1;
            end
         end
         CAL_CLSD_WAIT: begin
            if (timer_expired) begin
               state_d = CAL_DONE;
            end
         end
         default: begin
            state_d = CAL_IDLE;
         end
      endcase
   end

   // Reloaded with the closed-loop count in the cycle the oscillator wait ends
   wire [CNT_W-1:0] load_cycles = (state_q == CAL_OSC_WAIT) ? clsd_cycles : osc_cycles;

   wait_timer u_wait_timer (
      .clk_in      (clk_in),
      .resetn_in   (resetn_in),
      .load_in     (timer_load),
      .cycles_in   (load_cycles),
      .expired_out (timer_expired)
   );

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         state_q      <= CAL_IDLE;
         cal_busy_out <= 1'b0;
         cal_done_out <= 1'b0;
      end else begin
         state_q      <= state_d;
         cal_busy_out <= (state_d == CAL_OSC_WAIT) || (state_d == CAL_CLSD_WAIT);
         cal_done_out <= (state_d == CAL_DONE);
      end
   end

endmodule

// ===== verif/synth_cal_regs_checker.sv
// Port-level assertions for the synthesizer register slice.
// Assumes it is bound onto synth_cal_regs and sees only its ports.
`timescale 1ns/10ps
module synth_cal_regs_checker (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Avalon-MM slave
   input wire logic [synth_cal_pkg::ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic [1:0] avs_response_out,
   // Calibration and analog controls
   input wire logic cal_start_in,
   input wire logic synth1_narrow_bandwidth_out,
   input wire logic synth2_pump_pulse_stretch_out,
   input wire logic synth2_second_order_out,
   input wire logic synth2_third_order_out,
   input wire logic cal_busy_out,
   input wire logic cal_done_out
);
   import synth_cal_pkg::*;
   wire logic [7:0] idx = avs_address_in[9:2];
   wire logic taken = (avs_read_in | avs_write_in) & avs_waitrequest_out;
   wire logic mapped = (avs_address_in[1:0] == 2'h0) && (idx == IDX_SYNTH1_CALIBRATION_WAIT ||
      idx == IDX_SYNTH1_LOOP_BANDWIDTH || idx == IDX_SYNTH2_PUMP_STRETCH ||
      idx == IDX_SYNTH2_FILTER_ORDER || idx == IDX_CALIBRATION_STATUS);
   wire logic bw_wr = avs_write_in & avs_byteenable_in[0] & mapped & (idx == IDX_SYNTH1_LOOP_BANDWIDTH);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   ////////////////////////////////////////////////////////////////
   property p_ack_single; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
   a_ack_single: assert property (p_ack_single) else $error("ack longer than one cycle");
   property p_answer; taken |=> !avs_waitrequest_out; endproperty
   a_answer: assert property (p_answer) else $error("access not answered next cycle");
   property p_idle; !(avs_read_in | avs_write_in) |=> avs_waitrequest_out; endproperty
   a_idle: assert property (p_idle) else $error("ack without request");
   property p_rdata_zero; avs_waitrequest_out |-> avs_readdata_out == 32'h0; endproperty
   a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside ack");
   property p_resp; taken |=> avs_response_out == ($past(mapped) ? 2'h0 : 2'h3); endproperty
   a_resp: assert property (p_resp) else $error("wrong response code");
   property p_narrow;
      taken && bw_wr |-> ##2 synth1_narrow_bandwidth_out == $past(avs_writedata_in[0], 2);
   endproperty
   a_narrow: assert property (p_narrow) else $error("bandwidth output not following write");
   property p_order; !(synth2_second_order_out && synth2_third_order_out); endproperty
   a_order: assert property (p_order) else $error("both filter orders selected");
   property p_cal; cal_start_in && !cal_busy_out |=> cal_busy_out && !cal_done_out; endproperty
   a_cal: assert property (p_cal) else $error("calibration did not start");
endmodule
bind synth_cal_regs synth_cal_regs_checker i_synth_cal_regs_checker (.clk_in(clk_in), .resetn_in(resetn_in),
   .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .avs_response_out(avs_response_out), .cal_start_in(cal_start_in),
   .synth1_narrow_bandwidth_out(synth1_narrow_bandwidth_out),
   .synth2_pump_pulse_stretch_out(synth2_pump_pulse_stretch_out),
   .synth2_second_order_out(synth2_second_order_out), .synth2_third_order_out(synth2_third_order_out),
   .cal_busy_out(cal_busy_out), .cal_done_out(cal_done_out));

// ===== verif/synth_cal_regs_test.sv
// Directed bench for the synthesizer register slice.
// Assumes the checker is bound from its own file.
`timescale 1ns/10ps
module synth_cal_regs_test;
   import synth_cal_pkg::*;
   logic clk = 0, resetn = 0, rd = 0, wr = 0, start = 0;
   logic [9:0] addr = 10'h0;
   logic [31:0] wdata = 32'h0, q;
   logic [3:0] be = 4'hF;
   logic [1:0] resp;
   wire logic [31:0] rdata;
   wire logic [1:0] rsp;
   wire logic wreq, nb, st, so, to, busy, done;
   int mismatches = 0, checked = 0, n;
   time t0;
   logic [9:0] a_tab [4] = '{10'h1DC, 10'h1E0, 10'h20C, 10'h210};
   logic [31:0] r_tab [4] = '{32'h01, 32'h00, 32'h00, 32'h03};
   logic [31:0] w_tab [4] = '{32'hFFFFFFF5, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
   logic [31:0] m_tab [4] = '{32'h05, 32'h01, 32'h80, 32'h07};
   synth_cal_regs i_synth_cal_regs (.clk_in(clk), .resetn_in(resetn), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .avs_response_out(rsp),
      .cal_start_in(start), .synth1_narrow_bandwidth_out(nb), .synth2_pump_pulse_stretch_out(st),
      .synth2_second_order_out(so), .synth2_third_order_out(to), .cal_busy_out(busy),
      .cal_done_out(done));
   initial forever #2 clk = ~clk;
   ////////////////////////////////////////////////////////////////
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   // Two idle edges after release let the control outputs settle
   task automatic bus(logic w, logic [9:0] a, logic [31:0] d);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdata;
      resp = rsp;
      rd <= 1'b0;
      wr <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic reset_dut;
      resetn <= 1'b0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
   endtask
   task automatic summarize;
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      mismatches++;
      summarize;
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      reset_dut;
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, a_tab[i], 32'h0);
         chk("reset value", r_tab[i], q);
      end
      chk("order pins", 32'h2, {so, to});
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, a_tab[i], w_tab[i]);
         bus(1'b0, a_tab[i], 32'h0);
         chk("reserved mask", m_tab[i], q);
      end
      chk("controls", 32'hD, {nb, st, so, to});
      bus(1'b1, 10'h20C, 32'h0);
      chk("stretch apart", 32'h9, {nb, st, so, to});
      bus(1'b1, 10'h210, 32'h3);
      bus(1'b0, 10'h210, 32'h0);
      chk("filter code", 32'h3, q);
      chk("second order", 32'h2, {so, to});
      bus(1'b1, 10'h210, 32'h7);
      chk("third order", 32'h1, {so, to});
      be <= 4'hE;
      bus(1'b1, 10'h1E0, 32'h0);
      be <= 4'hF;
      bus(1'b0, 10'h1E0, 32'h0);
      chk("lane off", 32'h1, q);
      bus(1'b0, 10'h3FC, 32'h0);
      chk("unmapped resp", 32'h3, resp);
      chk("unmapped data", 32'h0, q);
      bus(1'b1, 10'h1DD, 32'h0);
      chk("misaligned resp", 32'h3, resp);
      bus(1'b0, 10'h1DC, 32'h0);
      chk("kept", 32'h05, q);
      // Shortest codes: 5000 plus 7500 cycles
      bus(1'b1, 10'h1DC, 32'h0);
      start <= 1'b1;
      @(posedge clk);
      t0 = $time;
      start <= 1'b0;
      @(posedge clk);
      chk("busy", 32'h1, busy);
      bus(1'b0, 10'h214, 32'h0);
      chk("status busy", 32'h1, q);
      // A late restart must not stretch the wait
      repeat (1000) @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      while (done !== 1'b1) @(posedge clk);
      n = int'(($time - t0) / 4);
      chk("cal length", 32'h1, n >= 12500 && n <= 12520);
      bus(1'b0, 10'h214, 32'h0);
      chk("status done", 32'h2, q);
      reset_dut;
      bus(1'b0, 10'h1DC, 32'h0);
      chk("reset again", 32'h1, q);
      chk("done cleared", 32'h0, done);
      summarize;
   end
endmodule
